/* File: include/csb_pkg.sv */
package csb_pkg;

	// Operation select from the instruction decoder
	typedef enum logic [4:0] {
		OP_COMPARE_IMMEDIATE = 5'h00,
		OP_SKIP_REG_CLEAR = 5'h01,
		OP_SKIP_REG_SET = 5'h02,
		OP_SKIP_IO_CLEAR = 5'h03,
		OP_SKIP_IO_SET = 5'h04,
		OP_BRANCH_FLAG_SET = 5'h05,
		OP_BRANCH_FLAG_CLEAR = 5'h06,
		OP_BRANCH_EQUAL = 5'h07,
		OP_BRANCH_NOT_EQUAL = 5'h08,
		OP_BRANCH_CARRY_SET = 5'h09,
		OP_BRANCH_CARRY_CLEAR = 5'h0a,
		OP_BRANCH_SAME_OR_HIGHER = 5'h0b,
		OP_BRANCH_LOWER = 5'h0c,
		OP_BRANCH_MINUS = 5'h0d,
		OP_BRANCH_PLUS = 5'h0e,
		OP_BRANCH_SIGNED_GE = 5'h0f,
		OP_BRANCH_SIGNED_LT = 5'h10,
		OP_BRANCH_HALF_CARRY_SET = 5'h11,
		OP_BRANCH_HALF_CARRY_CLEAR = 5'h12,
		OP_BRANCH_TRANSFER_SET = 5'h13,
		OP_BRANCH_TRANSFER_CLEAR = 5'h14,
		OP_BRANCH_OVERFLOW_SET = 5'h15,
		OP_BRANCH_OVERFLOW_CLEAR = 5'h16
	} csb_op_e;

	// Sequencer states, Gray along idle -> stall1 -> idle and stall2 -> stall1; idle -> stall2 flips both bits
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_STALL1 = 2'h1,
		ST_STALL2 = 2'h3
	} csb_state_e;

	// Status register bit positions
	localparam int unsigned FLAG_C = 0;
	localparam int unsigned FLAG_Z = 1;
	localparam int unsigned FLAG_N = 2;
	localparam int unsigned FLAG_V = 3;
	localparam int unsigned FLAG_S = 4;
	localparam int unsigned FLAG_H = 5;
	localparam int unsigned FLAG_T = 6;
	localparam int unsigned FLAG_I = 7;

	// Widths
	localparam int unsigned DATA_W = 8;
	localparam int unsigned BIT_SEL_W = 3;
	localparam int unsigned OFFSET_W = 7;

	// Cycle counts per outcome
	localparam logic [1:0] CYC_NOT_TAKEN = 2'h1;
	localparam logic [1:0] CYC_BRANCH_TAKEN = 2'h2;
	localparam logic [1:0] CYC_SKIP_ONE_WORD = 2'h2;
	localparam logic [1:0] CYC_SKIP_TWO_WORD = 2'h3;

	// Program counter steps
	localparam int unsigned PC_STEP_NEXT = 1;
	localparam int unsigned PC_STEP_SKIP_ONE = 2;
	localparam int unsigned PC_STEP_SKIP_TWO = 3;

	// Reset values
	localparam logic [DATA_W-1:0] STATUS_RESET = 8'h00;

endpackage

/* File: rtl/csb_unit.sv */
`timescale 1ns/1ps
module csb_unit #(
	parameter int unsigned PC_W = 16
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Request from the decoder
	input wire logic req_valid,
	input wire csb_pkg::csb_op_e req_op,
	input wire logic [csb_pkg::BIT_SEL_W-1:0] req_bit,
	input wire logic [csb_pkg::DATA_W-1:0] req_imm,
	input wire logic [csb_pkg::OFFSET_W-1:0] req_offset,
	input wire logic [PC_W-1:0] req_pc,
	input wire logic req_next_two_word,
	// Operands
	input wire logic [csb_pkg::DATA_W-1:0] reg_value,
	input wire logic [csb_pkg::DATA_W-1:0] io_value,
	input wire logic [csb_pkg::DATA_W-1:0] status_in,
	// Results
	output logic busy_ff,
	output logic done_ff,
	output logic taken_ff,
	output logic [PC_W-1:0] pc_next_ff,
	output logic status_we_ff,
	output logic [csb_pkg::DATA_W-1:0] status_out_ff
);
	import csb_pkg::*;

	csb_state_e state_ff, nxt_state;
	logic nxt_busy, nxt_done, nxt_taken, nxt_status_we;
	logic [PC_W-1:0] nxt_pc_next;
	logic [DATA_W-1:0] nxt_status_out;
	logic accept, cond, is_skip, is_branch;
	logic [1:0] cycles;
	logic [PC_W-1:0] offset_ext;
	logic [DATA_W-1:0] diff, cmp_status;

	assign accept = req_valid && (state_ff == ST_IDLE);
	assign offset_ext = {{(PC_W-OFFSET_W){req_offset[OFFSET_W-1]}}, req_offset};

	// Condition per operation; flags read straight from the status input
	always_comb
	begin
		cond = 1'b0;
		is_skip = 1'b0;
		is_branch = 1'b1;
		case (req_op)
			OP_COMPARE_IMMEDIATE: is_branch = 1'b0;
			OP_SKIP_REG_CLEAR:
			begin
				is_branch = 1'b0;
				is_skip = 1'b1;
				cond = ~reg_value[req_bit];
			end
			OP_SKIP_REG_SET:
			begin
				is_branch = 1'b0;
				is_skip = 1'b1;
				cond = reg_value[req_bit];
			end
			OP_SKIP_IO_CLEAR:
			begin
				is_branch = 1'b0;
				is_skip = 1'b1;
				cond = ~io_value[req_bit];
			end
			OP_SKIP_IO_SET:
			begin
				is_branch = 1'b0;
				is_skip = 1'b1;
				cond = io_value[req_bit];
			end
			OP_BRANCH_FLAG_SET: cond = status_in[req_bit];
			OP_BRANCH_FLAG_CLEAR: cond = ~status_in[req_bit];
			OP_BRANCH_EQUAL: cond = status_in[FLAG_Z];
			OP_BRANCH_NOT_EQUAL: cond = ~status_in[FLAG_Z];
			OP_BRANCH_CARRY_SET: cond = status_in[FLAG_C];
			OP_BRANCH_LOWER: cond = status_in[FLAG_C];
			OP_BRANCH_CARRY_CLEAR: cond = ~status_in[FLAG_C];
			OP_BRANCH_SAME_OR_HIGHER: cond = ~status_in[FLAG_C];
			OP_BRANCH_MINUS: cond = status_in[FLAG_N];
			OP_BRANCH_PLUS: cond = ~status_in[FLAG_N];
			// Signed tests use N xor V, not the stored S bit
			OP_BRANCH_SIGNED_GE: cond = ~(status_in[FLAG_N] ^ status_in[FLAG_V]);
			OP_BRANCH_SIGNED_LT: cond = status_in[FLAG_N] ^ status_in[FLAG_V];
			OP_BRANCH_HALF_CARRY_SET: cond = status_in[FLAG_H];
			OP_BRANCH_HALF_CARRY_CLEAR: cond = ~status_in[FLAG_H];
			OP_BRANCH_TRANSFER_SET: cond = status_in[FLAG_T];
			OP_BRANCH_TRANSFER_CLEAR: cond = ~status_in[FLAG_T];
			OP_BRANCH_OVERFLOW_SET: cond = status_in[FLAG_V];
			OP_BRANCH_OVERFLOW_CLEAR: cond = ~status_in[FLAG_V];
			default: is_branch = 1'b0;
		endcase
	end

	// Compare: subtract without writeback, S, T and I pass through
	always_comb
	begin
		diff = reg_value - req_imm;
		cmp_status = status_in;
		cmp_status[FLAG_Z] = (diff == 8'h00);
		cmp_status[FLAG_N] = diff[7];
		cmp_status[FLAG_V] = (reg_value[7] & ~req_imm[7] & ~diff[7])
			| (~reg_value[7] & req_imm[7] & diff[7]);
		cmp_status[FLAG_C] = (~reg_value[7] & req_imm[7]) | (req_imm[7] & diff[7])
			| (diff[7] & ~reg_value[7]);
		cmp_status[FLAG_H] = (~reg_value[3] & req_imm[3]) | (req_imm[3] & diff[3])
			| (diff[3] & ~reg_value[3]);
	end

	// Cycle count and target address of the accepted request
	always_comb
	begin
		cycles = CYC_NOT_TAKEN;
		nxt_pc_next = pc_next_ff;
		if (is_skip && cond)
		begin
			// Skipped instruction length decides step and cost
			cycles = req_next_two_word ? CYC_SKIP_TWO_WORD : CYC_SKIP_ONE_WORD;
		end
		else if (is_branch && cond)
		begin
			cycles = CYC_BRANCH_TAKEN;
		end
		if (accept)
		begin
			if (is_skip && cond)
			begin
				nxt_pc_next = req_next_two_word ? req_pc + PC_W'(PC_STEP_SKIP_TWO)
					: req_pc + PC_W'(PC_STEP_SKIP_ONE);
			end
			else if (is_branch && cond)
			begin
				nxt_pc_next = req_pc + offset_ext + PC_W'(PC_STEP_NEXT);
			end
			else
			begin
				nxt_pc_next = req_pc + PC_W'(PC_STEP_NEXT);
			end
		end
	end

	// Sequencer: stall states hold the core for the extra clocks
	always_comb
	begin
		nxt_state = state_ff;
		nxt_done = 1'b0;
		nxt_taken = taken_ff;
		nxt_status_we = 1'b0;
		nxt_status_out = status_out_ff;
		case (state_ff)
			ST_IDLE:
			begin
				if (accept)
				begin
					nxt_taken = (is_skip || is_branch) && cond;
					// Only compare writes flags; skips and branches never do
					if (req_op == OP_COMPARE_IMMEDIATE)
					begin
						nxt_status_we = 1'b1;
						nxt_status_out = cmp_status;
					end
					if (cycles == CYC_SKIP_TWO_WORD)
					begin
						nxt_state = ST_STALL2;
					end
					else if (cycles == CYC_BRANCH_TAKEN)
					begin
						nxt_state = ST_STALL1;
					end
					else
					begin
						nxt_done = 1'b1;
					end
				end
			end
			ST_STALL2: nxt_state = ST_STALL1;
			ST_STALL1:
			begin
				nxt_state = ST_IDLE;
				nxt_done = 1'b1;
			end
			default: nxt_state = ST_IDLE;
		endcase
		nxt_busy = (nxt_state != ST_IDLE);
	end

	// Register stage; every output is a flop
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			state_ff <= ST_IDLE;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
			taken_ff <= 1'b0;
			pc_next_ff <= '0;
			status_we_ff <= 1'b0;
			status_out_ff <= STATUS_RESET;
		end
		else
		begin
			state_ff <= nxt_state;
			busy_ff <= nxt_busy;
			done_ff <= nxt_done;
			taken_ff <= nxt_taken;
			pc_next_ff <= nxt_pc_next;
			status_we_ff <= nxt_status_we;
			status_out_ff <= nxt_status_out;
		end
	end

	// Checks
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);

	sequence s_done_after1;
		done_ff && !busy_ff;
	endsequence
	sequence s_done_after2;
		!done_ff && busy_ff ##1 done_ff;
	endsequence
	sequence s_done_after3;
		!done_ff ##1 !done_ff ##1 done_ff;
	endsequence

	a_cmp_one_clock: assert property (
		accept && req_op == OP_COMPARE_IMMEDIATE |=> s_done_after1 and status_we_ff
			and status_out_ff[FLAG_Z] == ($past(reg_value) == $past(req_imm)))
		else $error("compare not done in one clock");
	a_cmp_carry_flag: assert property (
		accept && req_op == OP_COMPARE_IMMEDIATE
			|=> status_out_ff[FLAG_C] == ($past(reg_value) < $past(req_imm)))
		else $error("compare carry wrong");
	a_skip_reg_clear: assert property (
		accept && req_op == OP_SKIP_REG_CLEAR && !reg_value[req_bit] && !req_next_two_word
			|=> s_done_after2 ##0 taken_ff && pc_next_ff == $past(req_pc, 2) + PC_W'(2))
		else $error("register bit clear skip wrong");
	a_skip_reg_set: assert property (
		accept && req_op == OP_SKIP_REG_SET && reg_value[req_bit] && req_next_two_word
			|=> s_done_after3 ##0 pc_next_ff == $past(req_pc, 3) + PC_W'(3))
		else $error("register bit set skip wrong");
	a_skip_io_none: assert property (
		accept && req_op == OP_SKIP_IO_CLEAR && io_value[req_bit]
			|=> s_done_after1 ##0 !taken_ff && pc_next_ff == $past(req_pc) + PC_W'(1))
		else $error("io skip taken wrongly");
	a_skip_io_set: assert property (
		accept && req_op == OP_SKIP_IO_SET && io_value[req_bit] |=> taken_ff && !status_we_ff)
		else $error("io bit set skip missed");
	a_branch_taken: assert property (
		accept && req_op == OP_BRANCH_FLAG_SET && status_in[req_bit]
			|=> s_done_after2 ##0 pc_next_ff == $past(req_pc, 2) + $past(offset_ext, 2)
				+ PC_W'(1))
		else $error("flag branch target wrong");
	a_branch_clear: assert property (
		accept && req_op == OP_BRANCH_FLAG_CLEAR && status_in[req_bit] |=> s_done_after1
			##0 !taken_ff)
		else $error("flag clear branch taken wrongly");
	a_signed_lt: assert property (
		accept && req_op == OP_BRANCH_SIGNED_LT
			|=> taken_ff == ($past(status_in[FLAG_N]) ^ $past(status_in[FLAG_V])))
		else $error("signed less-than decision wrong");
	a_no_flag_write: assert property (
		status_we_ff |-> $past(accept) && $past(req_op) == OP_COMPARE_IMMEDIATE)
		else $error("flags written by branch or skip");

endmodule

/* File: sim/tb_compare_skip_branch_unit.sv */
`timescale 1ns/1ps
module tb_compare_skip_branch_unit;
	import csb_pkg::*;
	// Stimulus, driven 1 ns after each rising edge
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic req_valid = 1'b0;
	csb_op_e req_op = OP_COMPARE_IMMEDIATE;
	logic [2:0] req_bit = 3'h0;
	logic [7:0] req_imm = 8'h00;
	logic [6:0] req_offset = 7'h00;
	logic [15:0] req_pc = 16'h0100;
	logic req_next_two_word = 1'b0;
	logic [7:0] reg_value = 8'h00;
	logic [7:0] io_value = 8'h00;
	logic [7:0] status_in = 8'h00;
	logic busy_ff, done_ff, taken_ff, status_we_ff;
	logic [15:0] pc_next_ff;
	logic [7:0] status_out_ff;
	int errors = 0;
	int n_checks = 0;
	int n_cyc;

	always #5 sys_clk = ~sys_clk;

	csb_unit #(.PC_W(16)) csb_unit_i (.sys_clk(sys_clk), .resetn(resetn),
		.req_valid(req_valid), .req_op(req_op), .req_bit(req_bit), .req_imm(req_imm),
		.req_offset(req_offset), .req_pc(req_pc), .req_next_two_word(req_next_two_word),
		.reg_value(reg_value), .io_value(io_value), .status_in(status_in),
		.busy_ff(busy_ff), .done_ff(done_ff), .taken_ff(taken_ff), .pc_next_ff(pc_next_ff),
		.status_we_ff(status_we_ff), .status_out_ff(status_out_ff));

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic conclude;
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// One request, then count edges until done; bounded so a hang cannot stall here
	task automatic run(input csb_op_e op, input logic [2:0] b, input logic [7:0] imm,
		input logic [6:0] k, input logic tw, input logic [7:0] rv, input logic [7:0] iv,
		input logic [7:0] st);
		// Idle edge first, so req_valid never falls and rises in one step
		@(posedge sys_clk);
		#1;
		req_valid = 1'b1;
		req_op = op;
		req_bit = b;
		req_imm = imm;
		req_offset = k;
		req_next_two_word = tw;
		reg_value = rv;
		io_value = iv;
		status_in = st;
		@(posedge sys_clk);
		#1;
		req_valid = 1'b0;
		n_cyc = 1;
		while (done_ff !== 1'b1 && n_cyc < 8)
		begin
			@(posedge sys_clk);
			#1;
			n_cyc++;
		end
	endtask

	task automatic expect_res(input logic [1:0] cyc, input logic tk, input logic [15:0] pc);
		chk(16'(n_cyc), {14'h0, cyc});
		chk({15'h0, taken_ff}, {15'h0, tk});
		chk(pc_next_ff, pc);
		chk({15'h0, status_we_ff}, {15'h0, req_op == OP_COMPARE_IMMEDIATE});
	endtask

	// Borrow, zero, sign and overflow corners of the subtraction
	task automatic t_compare;
		logic [7:0] d [4] = '{8'h10, 8'h00, 8'h80, 8'h3a};
		logic [7:0] kk [4] = '{8'h10, 8'h01, 8'h01, 8'h0f};
		logic [7:0] r, e;
		for (int i = 0; i < 4; i++)
		begin
			r = d[i] - kk[i];
			// Borrows from operand order, overflow from signs, not from a gate form
			e = {2'h3, (kk[i][3:0] > d[i][3:0]), 1'b1,
				((d[i][7] != kk[i][7]) && (r[7] != d[i][7])), r[7], (r == 8'h00), (kk[i] > d[i])};
			run(OP_COMPARE_IMMEDIATE, 3'h0, kk[i], 7'h00, 1'b0, d[i], 8'h00, 8'hd5);
			expect_res(CYC_NOT_TAKEN, 1'b0, req_pc + 16'h1);
			chk({8'h0, status_out_ff}, {8'h0, e});
		end
	endtask

	// Every skip kind, every bit, both bit values and both next lengths
	task automatic t_skips;
		logic [7:0] m;
		logic tk;
		logic [15:0] pe;
		logic [1:0] ce;
		for (int o = 1; o < 5; o++)
			for (int b = 0; b < 8; b++)
				for (int v = 0; v < 4; v++)
				begin
					m = v[0] ? 8'h01 << b : ~(8'h01 << b);
					tk = v[0] == (o % 2 == 0);
					ce = !tk ? CYC_NOT_TAKEN : v[1] ? CYC_SKIP_TWO_WORD : CYC_SKIP_ONE_WORD;
					pe = req_pc + (!tk ? 16'h1 : v[1] ? 16'h3 : 16'h2);
					run(csb_op_e'(o), b[2:0], 8'h00, 7'h00, v[1], o < 3 ? m : ~m, o < 3 ? ~m : m, 8'hff);
					expect_res(ce, tk, pe);
				end
	endtask

	// Named branches over flag patterns, forward and backward offsets; 9 marks N xor V
	task automatic t_branches;
		int fl [16] = '{1, 1, 0, 0, 0, 0, 2, 2, 9, 9, 5, 5, 6, 6, 3, 3};
		int pol [16] = '{1, 0, 1, 0, 0, 1, 1, 0, 0, 1, 1, 0, 1, 0, 1, 0};
		logic [7:0] sts [3] = '{8'h00, 8'hff, 8'h24};
		logic [6:0] k;
		logic f, tk;
		logic [15:0] pe;
		logic [1:0] ce;
		for (int i = 0; i < 16; i++)
			for (int s = 0; s < 3; s++)
			begin
				k = s[0] ? 7'h40 : 7'h3f;
				f = fl[i] == 9 ? sts[s][2] ^ sts[s][3] : sts[s][fl[i]];
				tk = f == pol[i][0];
				ce = tk ? CYC_BRANCH_TAKEN : CYC_NOT_TAKEN;
				pe = req_pc + (tk ? {{9{k[6]}}, k} + 16'h1 : 16'h1);
				run(csb_op_e'(7 + i), 3'h0, 8'h00, k, 1'b1, 8'h00, 8'h00, sts[s]);
				if (i < 8)
					expect_res(ce, tk, pe);
				else
					expect_res(ce, tk, pe);
			end
		// Indexed forms on each status bit
		for (int b = 0; b < 8; b++)
			for (int v = 0; v < 4; v++)
			begin
				tk = v[0] == v[1];
				run(v[1] ? OP_BRANCH_FLAG_SET : OP_BRANCH_FLAG_CLEAR, b[2:0], 8'h00, 7'h7e, 1'b0,
					8'h00, 8'h00, v[0] ? 8'h01 << b : ~(8'h01 << b));
				ce = tk ? CYC_BRANCH_TAKEN : CYC_NOT_TAKEN;
				pe = req_pc + (tk ? 16'hffff : 16'h1);
				expect_res(ce, tk, pe);
			end
	endtask

	// A compare shown only during a stall must leave no trace
	task automatic t_busy_ignore;
		logic [7:0] so;
		so = status_out_ff;
		run(OP_BRANCH_EQUAL, 3'h0, 8'h00, 7'h05, 1'b0, 8'h00, 8'h00, 8'h02);
		expect_res(CYC_BRANCH_TAKEN, 1'b1, req_pc + 16'h6);
		// Taken branch accepted, then a compare held through its stall edge
		@(posedge sys_clk);
		#1;
		req_valid = 1'b1;
		req_op = OP_BRANCH_NOT_EQUAL;
		status_in = 8'h00;
		@(posedge sys_clk);
		#1;
		chk({15'h0, busy_ff}, 16'h1);
		req_op = OP_COMPARE_IMMEDIATE;
		req_imm = 8'h01;
		@(posedge sys_clk);
		#1;
		req_valid = 1'b0;
		chk({14'h0, done_ff, status_we_ff}, 16'h2);
		@(posedge sys_clk);
		#1;
		chk({14'h0, done_ff, status_we_ff}, 16'h0);
		chk({7'h0, taken_ff, status_out_ff}, {8'h01, so});
		chk(pc_next_ff, req_pc + 16'h6);
	endtask

	// Watchdog far beyond the roughly 570 cycles the tests need
	initial
	begin
		#200000;
		errors++;
		conclude();
	end

	initial
	begin
		repeat (3) @(posedge sys_clk);
		#1;
		resetn = 1'b1;
		@(posedge sys_clk);
		#1;
		t_compare();
		t_skips();
		t_branches();
		t_busy_ignore();
		conclude();
	end
endmodule
